// [hw/dz_pkg.sv]
// Shared constants, types and address decoding for the data-zone access link.
// Assumes both ends run on one clock and import this package whole.
package dz_pkg;

  // Status codes returned with every finished access.
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_MISCOMPARE = 8'h01;
  localparam logic [7:0] ST_PARSE = 8'h03;
  localparam logic [7:0] ST_EXEC = 8'h0f;

  // Per-slot access masks, one bit per slot index.
  localparam logic [15:0] PLAIN_WR_SLOTS = 16'ha300;
  localparam logic [15:0] ENC_WR_SLOTS = 16'h0060;
  localparam logic [15:0] PLAIN_RD_SLOTS = 16'hfd00;
  localparam logic [15:0] VALIDATE_SLOTS_DEFAULT = 16'hff00;

  // Validation nibble codes held in the top of the first stored byte.
  localparam logic [3:0] KEY_INVALID = 4'ha;
  localparam logic [3:0] KEY_VALID = 4'h5;

  // Slot geometry in 32-bit words.
  localparam logic [3:0] BIG_SLOT = 4'h8;
  localparam logic [3:0] SLOT8_LAST_BLK = 4'hc;
  localparam logic [3:0] SMALL_LAST_BLK = 4'h1;
  localparam logic [2:0] SMALL_LAST_OFF = 3'h0;
  localparam logic [3:0] LARGE_LAST_BLK = 4'h2;
  localparam logic [2:0] LARGE_LAST_OFF = 3'h1;
  localparam logic [8:0] SMALL_WORDS = 9'h009;
  localparam logic [8:0] LARGE_WORDS = 9'h012;
  localparam logic [8:0] BIG_BASE = 9'h048;
  localparam logic [8:0] LARGE_BASE = 9'h0b0;
  localparam int MEM_WORDS = 302;

  // Beats per transfer.
  localparam logic [3:0] BEATS_WORD = 4'h1;
  localparam logic [3:0] BEATS_BLOCK = 4'h8;
  localparam logic [3:0] BEATS_SMALL_TAIL = 4'h1;
  localparam logic [3:0] BEATS_LARGE_TAIL = 4'h2;

  // Key and message layout in bytes, key image sizes in 32-bit words.
  localparam logic [6:0] PAD_BYTES = 7'h04;
  localparam logic [6:0] COORD_BYTES = 7'h20;
  localparam logic [6:0] KEYGEN_PAD_BYTES = 7'h19;
  localparam logic [6:0] STORED_KEY_BYTES = 7'h48;
  localparam logic [6:0] KEYGEN_MSG_BYTES = 7'h59;
  localparam logic [6:0] CERT_MAX_BYTES = 7'h48;
  localparam logic [4:0] PUB_WORDS = 5'h12;
  localparam logic [4:0] PRIV_WORDS = 5'h09;

  // Link operations.
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ENC_WRITE, OP_VALIDATE, OP_INVALIDATE, OP_HASH_STORED, OP_HASH_KEYGEN
  } op_e;

  // Host-side formatting of a multi-word store.
  typedef enum logic [1:0] {FMT_RAW, FMT_PUB, FMT_PRIV, FMT_CERT} fmt_e;

  // Controller states of each end.
  typedef enum logic [2:0] {D_IDLE, D_WRITE, D_READ, D_STREAM, D_DONE} dev_state_e;
  typedef enum logic [2:0] {H_IDLE, H_REQ, H_DATA, H_WAIT, H_RESP} host_state_e;

  // Block field, whose width depends on the slot size group.
  function automatic logic [3:0] block_of(input logic [15:0] a);
    if (a[6:3] < BIG_SLOT) begin
      return {3'h0, a[8]};
    end else if (a[6:3] == BIG_SLOT) begin
      return a[11:8];
    end
    return {2'h0, a[9:8]};
  endfunction

  // True when block and offset lie inside the addressed slot and a block access starts at offset 0.
  function automatic logic addr_ok(input logic [15:0] a, input logic blk_acc);
    logic [3:0] b;
    logic ok;
    b = block_of(a);
    if (a[6:3] < BIG_SLOT) begin
      ok = (b == 4'h0) || (b == SMALL_LAST_BLK && a[2:0] <= SMALL_LAST_OFF);
    end else if (a[6:3] == BIG_SLOT) begin
      ok = (b <= SLOT8_LAST_BLK);
    end else begin
      ok = (b < LARGE_LAST_BLK) || (b == LARGE_LAST_BLK && a[2:0] <= LARGE_LAST_OFF);
    end
    return ok && !(blk_acc && a[2:0] != 3'h0);
  endfunction

  // Word beats moved by one transfer; a block access to a tail block moves only its valid words.
  function automatic logic [3:0] beats_of(input logic [15:0] a, input logic blk_acc);
    if (!blk_acc) begin
      return BEATS_WORD;
    end else if (a[6:3] < BIG_SLOT && block_of(a) == SMALL_LAST_BLK) begin
      return BEATS_SMALL_TAIL;
    end else if (a[6:3] > BIG_SLOT && block_of(a) == LARGE_LAST_BLK) begin
      return BEATS_LARGE_TAIL;
    end
    return BEATS_BLOCK;
  endfunction

  // First memory word of the addressed slot.
  function automatic logic [8:0] word_base(input logic [15:0] a);
    if (a[6:3] < BIG_SLOT) begin
      return 9'({5'h0, a[6:3]} * SMALL_WORDS);
    end else if (a[6:3] == BIG_SLOT) begin
      return BIG_BASE;
    end
    return 9'(LARGE_BASE + ({5'h0, a[6:3]} - 9'h009) * LARGE_WORDS);
  endfunction

  // Memory word addressed by slot, block and offset.
  function automatic logic [8:0] word_index(input logic [15:0] a);
    return 9'(word_base(a) + {2'h0, block_of(a), a[2:0]});
  endfunction

endpackage

// [hw/dz_link_if.sv]
// Link between the host controller end and the data-zone device end.
// Assumes one shared clock; every signal but the host's address and block flag is driven from a flip-flop.
`timescale 1ns/100ps
`default_nettype none
interface dz_link_if;
  import dz_pkg::*;
  logic req_valid;
  op_e req_op;
  logic [15:0] req_addr;
  logic req_block;
  logic wr_valid;
  logic [31:0] wr_data;
  logic req_ready;
  logic rd_valid;
  logic [31:0] rd_data;
  logic done;
  logic [7:0] status;

  // Device end answers requests and owns the memory.
  modport dev (
    input req_valid, req_op, req_addr, req_block, wr_valid, wr_data,
    output req_ready, rd_valid, rd_data, done, status
  );

  // Host end issues requests and write beats.
  modport host (
    output req_valid, req_op, req_addr, req_block, wr_valid, wr_data,
    input req_ready, rd_valid, rd_data, done, status
  );
endinterface
`default_nettype wire

// [hw/dz_device.sv]
// Data-zone device end: address decode, slot policy, word memory, key validation nibble
// and the byte stream that feeds the digest engine.
// Assumes the host end on the same clock drives the link; digest logic sits outside.
//
// Overview of operation
// - Address: offset 2:0, slot 6:3, block by group.
// - Slots 0-7: 36 bytes, block 1 one word.
// - Slot 8: blocks 0 to 0xC, 416 bytes.
// - Slots 9-15: 72 bytes, block 2 two words.
// - Most significant byte first, lowest address.
// - Host sends private key: 4 pad, 32 key.
// - Command public key: X then Y, 64 bytes.
// - Stored public key: pad, X, pad, Y.
// - Key-generate digest: 25 pad bytes, X, Y.
// - Key validation digest over 72 stored bytes.
// - Validation nibble: write 0xA, validate 0x5.
// - Stored public keys only in slots 8-15.
// - Signature: R then S, 32 bytes each.
// - Host rebuilds certificate from 72-byte record.
// - Per-slot plain, encrypted and read policy.
`timescale 1ns/100ps
`default_nettype none
module dz_device
  import dz_pkg::*;
#(
  parameter logic [15:0] VALIDATED_SLOTS = VALIDATE_SLOTS_DEFAULT
) (
  // Clock, reset and clock enable.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Link to the host end.
  dz_link_if.dev link,
  // Result of the signature check for a validate request.
  input wire logic sig_match_in,
  // Byte stream to the digest engine.
  output logic [7:0] sha_byte_out,
  output logic sha_valid_out,
  output logic sha_last_out
);

  // Key words live here; contents are data, not control, and have no reset.
  logic [31:0] mem [0:MEM_WORDS-1];

  dev_state_e state, next_state;
  op_e op, next_op;
  logic [15:0] addr, next_addr;
  logic [3:0] beats, next_beats;
  logic [6:0] cnt, next_cnt;
  logic ready, next_ready;
  logic rd_valid, next_rd_valid;
  logic [31:0] rd_data, next_rd_data;
  logic done, next_done;
  logic [7:0] status, next_status;
  logic [7:0] next_sha_byte;
  logic next_sha_valid, next_sha_last;
  logic mem_we;
  logic [8:0] mem_idx;
  logic [31:0] mem_wdata;
  logic [8:0] cur_idx;
  logic [6:0] src_pos;
  logic src_zero;
  logic [31:0] src_word;
  logic [3:0] in_slot;

  // Link outputs come straight from registers.
  assign link.req_ready = ready;
  assign link.rd_valid = rd_valid;
  assign link.rd_data = rd_data;
  assign link.done = done;
  assign link.status = status;

  // Byte position inside the slot that the digest stream sends next.
  always_comb begin
    src_zero = 1'b0;
    src_pos = cnt;
    if (op == OP_HASH_KEYGEN) begin
      if (cnt < KEYGEN_PAD_BYTES) begin
        src_zero = 1'b1;
        src_pos = 7'h00;
      end else if (7'(cnt - KEYGEN_PAD_BYTES) < COORD_BYTES) begin
        src_pos = 7'(cnt - KEYGEN_PAD_BYTES + PAD_BYTES);
      end else begin
        src_pos = 7'(cnt - KEYGEN_PAD_BYTES + PAD_BYTES + PAD_BYTES);
      end
    end
    src_word = mem[9'(word_base(addr) + {4'h0, src_pos[6:2]})];
  end

  // Next-state logic for the access controller.
  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_beats = beats;
    next_cnt = cnt;
    next_ready = ready;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_done = 1'b0;
    next_status = status;
    next_sha_byte = sha_byte_out;
    next_sha_valid = 1'b0;
    next_sha_last = 1'b0;
    mem_we = 1'b0;
    mem_idx = 9'h000;
    mem_wdata = 32'h0000_0000;
    in_slot = link.req_addr[6:3];
    cur_idx = 9'(word_index(addr) + {2'h0, cnt});
    case (state)
      D_IDLE: begin
        if (link.req_valid && ready) begin
          next_ready = 1'b0;
          next_op = link.req_op;
          next_addr = link.req_addr;
          next_beats = beats_of(link.req_addr, link.req_block);
          next_cnt = 7'h00;
          next_status = ST_OK;
          next_state = D_DONE;
          if (!addr_ok(link.req_addr, link.req_block)) begin
            next_status = ST_PARSE;
          end else begin
            case (link.req_op)
              OP_READ: begin
                if (PLAIN_RD_SLOTS[in_slot]) next_state = D_READ;
                else next_status = ST_EXEC;
              end
              OP_WRITE: begin
                if (PLAIN_WR_SLOTS[in_slot]) next_state = D_WRITE;
                else next_status = ST_EXEC;
              end
              OP_ENC_WRITE: begin
                if (ENC_WR_SLOTS[in_slot]) next_state = D_WRITE;
                else next_status = ST_EXEC;
              end
              OP_VALIDATE, OP_INVALIDATE: begin
                if (in_slot < BIG_SLOT) begin
                  next_status = ST_PARSE;
                end else if (!VALIDATED_SLOTS[in_slot]) begin
                  next_status = ST_EXEC;
                end else if (link.req_op == OP_VALIDATE && !sig_match_in) begin
                  next_status = ST_MISCOMPARE;
                end else begin
                  mem_we = 1'b1;
                  mem_idx = word_base(link.req_addr);
                  mem_wdata = {(link.req_op == OP_VALIDATE) ? KEY_VALID : KEY_INVALID,
                               mem[word_base(link.req_addr)][27:0]};
                end
              end
              OP_HASH_STORED, OP_HASH_KEYGEN: begin
                if (in_slot < BIG_SLOT) next_status = ST_PARSE;
                else next_state = D_STREAM;
              end
              default: next_status = ST_PARSE;
            endcase
          end
        end
      end
      D_WRITE: begin
        if (link.wr_valid) begin
          mem_we = 1'b1;
          mem_idx = cur_idx;
          mem_wdata = link.wr_data;
          if (VALIDATED_SLOTS[addr[6:3]] && addr[6] && cur_idx == word_base(addr)) begin
            mem_wdata[31:28] = KEY_INVALID;
          end
          next_cnt = 7'(cnt + 7'h01);
          if (cnt == 7'({3'h0, beats} - 7'h01)) next_state = D_DONE;
        end
      end
      D_READ: begin
        next_rd_valid = 1'b1;
        next_rd_data = mem[cur_idx];
        next_cnt = 7'(cnt + 7'h01);
        if (cnt == 7'({3'h0, beats} - 7'h01)) next_state = D_DONE;
      end
      D_STREAM: begin
        next_sha_valid = 1'b1;
        next_sha_byte = src_zero ? 8'h00 : src_word[8'(31 - 8 * src_pos[1:0]) -: 8];
        next_cnt = 7'(cnt + 7'h01);
        if (cnt == ((op == OP_HASH_KEYGEN) ? KEYGEN_MSG_BYTES : STORED_KEY_BYTES) - 7'h01) begin
          next_sha_last = 1'b1;
          next_state = D_DONE;
        end
      end
      D_DONE: begin
        next_done = 1'b1;
        next_ready = 1'b1;
        next_state = D_IDLE;
      end
      default: next_state = D_IDLE;
    endcase
  end

  // Controller registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= D_IDLE;
      op <= OP_READ;
      addr <= 16'h0000;
      beats <= 4'h0;
      cnt <= 7'h00;
      ready <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
      done <= 1'b0;
      status <= 8'h00;
      sha_byte_out <= 8'h00;
      sha_valid_out <= 1'b0;
      sha_last_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      beats <= next_beats;
      cnt <= next_cnt;
      ready <= next_ready;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      done <= next_done;
      status <= next_status;
      sha_byte_out <= next_sha_byte;
      sha_valid_out <= next_sha_valid;
      sha_last_out <= next_sha_last;
    end
  end

  // Memory write port; refused requests never raise the write enable.
  always_ff @(posedge clk_in) begin
    if (!rst_in && ce_in && mem_we) begin
      mem[mem_idx] <= mem_wdata;
    end
  end

endmodule // dz_device
`default_nettype wire

// [hw/dz_host.sv]
// Host controller end: issues link requests, formats key and certificate images into
// single-word writes and collects read beats.
// Assumes the device end on the same clock answers on the link.
`timescale 1ns/100ps
`default_nettype none
module dz_host
  import dz_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Link to the device end.
  dz_link_if.host link,
  // User command.
  input wire logic cmd_valid_in,
  input wire op_e cmd_op_in,
  input wire fmt_e cmd_fmt_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic cmd_block_in,
  input wire logic [6:0] cmd_len_in,
  input wire logic [575:0] src_in,
  output logic cmd_ready_out,
  // User response.
  output logic resp_valid_out,
  output logic [7:0] resp_status_out,
  output logic [255:0] resp_data_out
);

  host_state_e state, next_state;
  op_e op, next_op;
  fmt_e fmt, next_fmt;
  logic [15:0] addr, next_addr;
  logic blk, next_blk;
  logic [575:0] image, next_image;
  logic [4:0] nwords, next_nwords;
  logic [4:0] widx, next_widx;
  logic [3:0] cnt, next_cnt;
  logic [3:0] rcnt, next_rcnt;
  logic [3:0] nbeats;
  logic req_valid, next_req_valid;
  logic wr_valid, next_wr_valid;
  logic [31:0] wr_data, next_wr_data;
  logic next_cmd_ready, next_resp_valid;
  logic [7:0] next_resp_status;
  logic [255:0] next_resp_data;
  logic is_write;

  // Link outputs come from registers; address and block flag are muxed by the format.
  assign link.req_valid = req_valid;
  assign link.req_op = op;
  assign link.req_addr = (fmt == FMT_RAW) ? addr : {6'h0, widx[4:3], 1'b0, addr[6:3], widx[2:0]};
  assign link.req_block = (fmt == FMT_RAW) ? blk : 1'b0;
  assign link.wr_valid = wr_valid;
  assign link.wr_data = wr_data;

  // Word w of a 72-byte image, first word at the top.
  function automatic logic [31:0] img_word(input logic [575:0] img, input logic [4:0] w);
    return img[10'(575 - 32 * w) -: 32];
  endfunction

  // Builds the slot image for the chosen format.
  function automatic logic [575:0] build_image(input fmt_e f, input logic [575:0] s);
    case (f)
      FMT_PUB: return {32'h0000_0000, s[511:256], 32'h0000_0000, s[255:0]};
      FMT_PRIV: return {32'h0000_0000, s[255:0], 288'h0};
      default: return s;
    endcase
  endfunction

  assign nbeats = (fmt == FMT_RAW) ? beats_of(addr, blk) : BEATS_WORD;
  assign is_write = (op == OP_WRITE) || (op == OP_ENC_WRITE);

  // Next-state logic for the request sequencer.
  always_comb begin
    next_state = state;
    next_op = op;
    next_fmt = fmt;
    next_addr = addr;
    next_blk = blk;
    next_image = image;
    next_nwords = nwords;
    next_widx = widx;
    next_cnt = cnt;
    next_rcnt = rcnt;
    next_req_valid = req_valid;
    next_wr_valid = 1'b0;
    next_wr_data = wr_data;
    next_cmd_ready = cmd_ready_out;
    next_resp_valid = 1'b0;
    next_resp_status = resp_status_out;
    next_resp_data = resp_data_out;
    case (state)
      H_IDLE: begin
        if (cmd_valid_in && cmd_ready_out) begin
          next_cmd_ready = 1'b0;
          next_op = cmd_op_in;
          next_fmt = cmd_fmt_in;
          next_addr = cmd_addr_in;
          next_blk = cmd_block_in;
          next_image = build_image(cmd_fmt_in, src_in);
          next_widx = 5'h00;
          next_resp_data = 256'h0;
          next_resp_status = ST_OK;
          next_nwords = (cmd_fmt_in == FMT_PUB) ? PUB_WORDS :
            (cmd_fmt_in == FMT_PRIV) ? PRIV_WORDS : 5'(({1'b0, cmd_len_in} + 8'h03) >> 2);
          next_state = H_REQ;
          next_req_valid = 1'b1;
          // Public key image needs slot 8 or a large slot.
          if (cmd_fmt_in == FMT_PUB && cmd_addr_in[6:3] < BIG_SLOT) begin
            next_resp_status = ST_PARSE;
          end
          if (cmd_fmt_in == FMT_CERT && (cmd_len_in > CERT_MAX_BYTES || cmd_len_in == 7'h00)) begin
            next_resp_status = ST_PARSE;
          end
          if (next_resp_status != ST_OK) begin
            next_req_valid = 1'b0;
            next_state = H_RESP;
          end
        end
      end
      H_REQ: begin
        next_cnt = 4'h0;
        next_rcnt = 4'h0;
        if (link.req_ready) begin
          next_req_valid = 1'b0;
          next_state = H_WAIT;
          if (is_write) begin
            // First beat carries the lowest-address bytes.
            next_wr_valid = 1'b1;
            next_wr_data = img_word(image, (fmt == FMT_RAW) ? 5'h00 : widx);
            next_cnt = 4'h1;
            if (nbeats != BEATS_WORD) next_state = H_DATA;
          end
        end
      end
      H_DATA: begin
        next_wr_valid = 1'b1;
        next_wr_data = img_word(image, {1'b0, cnt});
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == 4'(nbeats - 4'h1)) next_state = H_WAIT;
        if (link.done) begin
          next_wr_valid = 1'b0;
          next_resp_status = link.status;
          next_state = H_RESP;
        end
      end
      H_WAIT: begin
        if (link.rd_valid) begin
          next_resp_data[9'(255 - 32 * rcnt) -: 32] = link.rd_data;
          next_rcnt = 4'(rcnt + 4'h1);
        end
        if (link.done) begin
          next_resp_status = link.status;
          next_state = H_RESP;
          if (fmt != FMT_RAW && link.status == ST_OK && 5'(widx + 5'h01) < nwords) begin
            next_widx = 5'(widx + 5'h01);
            next_req_valid = 1'b1;
            next_state = H_REQ;
          end
        end
      end
      H_RESP: begin
        next_resp_valid = 1'b1;
        next_cmd_ready = 1'b1;
        next_state = H_IDLE;
      end
      default: next_state = H_IDLE;
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= H_IDLE;
      op <= OP_READ;
      fmt <= FMT_RAW;
      addr <= 16'h0000;
      blk <= 1'b0;
      image <= 576'h0;
      nwords <= 5'h00;
      widx <= 5'h00;
      cnt <= 4'h0;
      rcnt <= 4'h0;
      req_valid <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 32'h0000_0000;
      cmd_ready_out <= 1'b1;
      resp_valid_out <= 1'b0;
      resp_status_out <= 8'h00;
      resp_data_out <= 256'h0;
    end else if (ce_in) begin
      state <= next_state;
      op <= next_op;
      fmt <= next_fmt;
      addr <= next_addr;
      blk <= next_blk;
      image <= next_image;
      nwords <= next_nwords;
      widx <= next_widx;
      cnt <= next_cnt;
      rcnt <= next_rcnt;
      req_valid <= next_req_valid;
      wr_valid <= next_wr_valid;
      wr_data <= next_wr_data;
      cmd_ready_out <= next_cmd_ready;
      resp_valid_out <= next_resp_valid;
      resp_status_out <= next_resp_status;
      resp_data_out <= next_resp_data;
    end
  end

endmodule // dz_host
`default_nettype wire

// [verif/dz_link_properties.sv]
// Concurrent checks on the link between the host end and the device end.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/100ps
`default_nettype none
module dz_link_properties
  import dz_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Link signals.
  input wire logic req_valid,
  input wire op_e req_op,
  input wire logic [15:0] req_addr,
  input wire logic req_block,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic done,
  input wire logic [7:0] status
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Taken request, its slot and a block 0 offset 0 address.
  logic take;
  logic blk0;
  logic [3:0] slot;
  assign take = req_valid && req_ready;
  assign slot = req_addr[6:3];
  assign blk0 = req_addr[11:7] == 5'h00 && req_addr[2:0] == 3'h0;
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_SLOT8_RANGE: assert property (take && req_op == OP_READ && slot == 4'h8
    && req_addr[11:8] > 4'hc |-> ##2 done && status == 8'h03) else $error("slot 8 range");
  AST_LARGE_TAIL: assert property (take && req_op == OP_READ && slot > 4'h8
    && req_addr[9:8] == 2'h2 && req_addr[2:0] > 3'h1 |-> ##2 done && status == 8'h03)
    else $error("large slot tail range");
  AST_SMALL_TAIL: assert property (take && slot < 4'h8 && req_addr[8]
    && req_addr[2:0] != 3'h0 |-> ##2 done && status != 8'h00) else $error("small slot tail");
  AST_WR_POLICY: assert property (take && req_op == OP_WRITE && blk0
    && !PLAIN_WR_SLOTS[slot] |-> ##2 done && status == 8'h0f) else $error("write policy");
  AST_ENC_POLICY: assert property (take && req_op == OP_ENC_WRITE && blk0
    && !ENC_WR_SLOTS[slot] |-> ##2 done && status == 8'h0f) else $error("enc policy");
  AST_RD_POLICY: assert property (take && req_op == OP_READ && blk0
    && !PLAIN_RD_SLOTS[slot] |-> ##2 done && status == 8'h0f) else $error("read policy");
  AST_BIG_BLOCK: assert property (take && req_op == OP_READ && req_block && slot == 4'h8
    && blk0 |-> ##2 rd_valid [*8] ##1 !rd_valid && done) else $error("slot 8 block beats");
  AST_TAIL_BLOCK: assert property (take && req_op == OP_READ && req_block && slot > 4'h8
    && req_addr[9:7] == 3'h4 && req_addr[2:0] == 3'h0 |-> ##2 rd_valid [*2] ##1 !rd_valid
    && done) else $error("tail block beats");
  AST_WORD_WRITE: assert property (take && req_op == OP_WRITE && !req_block
    && slot == 4'h8 && blk0 |-> ##3 done && status == 8'h00) else $error("word write");
endmodule // dz_link_properties
`default_nettype wire

// [verif/data_zone_address_key_format_bench.sv]
// Bench joining the host end and the device end over the link, driven by user commands.
// Assumes the package, link and both ends are compiled first.
`timescale 1ns/100ps
`default_nettype none
module data_zone_address_key_format_bench;
  import dz_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic sig_match_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  op_e cmd_op_in = OP_READ;
  fmt_e cmd_fmt_in = FMT_RAW;
  logic [15:0] cmd_addr_in = 16'h0000;
  logic cmd_block_in = 1'b0;
  logic [6:0] cmd_len_in = 7'h00;
  logic [575:0] src_in = '0;
  logic cmd_ready_out, resp_valid_out, sha_valid_out, sha_last_out;
  logic [7:0] resp_status_out, sha_byte_out;
  logic [255:0] resp_data_out, x_val, y_val;
  logic [575:0] img;
  logic [711:0] kimg;
  logic [31:0] wq[$];
  logic [7:0] sq[$];
  op_e ops[3] = '{OP_WRITE, OP_ENC_WRITE, OP_READ};
  op_e vops[3] = '{OP_VALIDATE, OP_INVALIDATE, OP_VALIDATE};
  logic [15:0] oks[3] = '{16'ha300, 16'h0060, 16'hfd00};
  int errors = 0, samples_checked = 0, cycles = 0, lasts = 0;
  dz_link_if link();
  dz_device dz_device_inst(.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .link(link),
    .sig_match_in(sig_match_in), .sha_byte_out(sha_byte_out), .sha_valid_out(sha_valid_out),
    .sha_last_out(sha_last_out));
  dz_host dz_host_inst(.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .link(link),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_fmt_in(cmd_fmt_in),
    .cmd_addr_in(cmd_addr_in), .cmd_block_in(cmd_block_in), .cmd_len_in(cmd_len_in),
    .src_in(src_in), .cmd_ready_out(cmd_ready_out), .resp_valid_out(resp_valid_out),
    .resp_status_out(resp_status_out), .resp_data_out(resp_data_out));
  dz_link_properties dz_link_properties_inst(.clk_in(clk_in), .rst_in(rst_in),
    .req_valid(link.req_valid), .req_op(link.req_op), .req_addr(link.req_addr),
    .req_block(link.req_block), .req_ready(link.req_ready), .rd_valid(link.rd_valid),
    .done(link.done), .status(link.status));
  // Clock, hang guard and capture of write beats and digest bytes.
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
    if (link.wr_valid) wq.push_back(link.wr_data);
    if (sha_valid_out) sq.push_back(sha_byte_out);
    if (sha_last_out) lasts++;
  end
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Compares one result and counts it.
  task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Issues one user command and waits for its response.
  task automatic run(input op_e op, input fmt_e fmt, input logic [15:0] a, input logic b,
                     input logic [6:0] len);
    wq.delete();
    sq.delete();
    lasts = 0;
    cmd_op_in = op;
    cmd_fmt_in = fmt;
    cmd_addr_in = a;
    cmd_block_in = b;
    cmd_len_in = len;
    cmd_valid_in = 1'b1;
    do @(posedge clk_in); while (!cmd_ready_out);
    #1;
    cmd_valid_in = 1'b0;
    do @(posedge clk_in); while (!resp_valid_out);
    #1;
  endtask
  // Main sequence.
  initial begin
    for (int i = 0; i < 32; i++) begin
      x_val[255-8*i -: 8] = 8'(i + 1);
      y_val[255-8*i -: 8] = 8'(i + 8'h81);
    end
    img = {32'h0, x_val, 32'h0, y_val};
    kimg = {200'h0, x_val, y_val};
    repeat (12) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 16; s++) begin
        run(ops[k], FMT_RAW, 16'(s << 3), 1'b0, 7'h00);
        chk("slot policy", oks[k][s] ? 8'h00 : 8'h0f, resp_status_out);
      end
    end
    run(OP_READ, FMT_RAW, 16'h0d40, 1'b0, 7'h00);
    chk("slot 8 block d", 8'h03, resp_status_out);
    run(OP_READ, FMT_RAW, 16'h0252, 1'b0, 7'h00);
    chk("tail offset 2", 8'h03, resp_status_out);
    run(OP_READ, FMT_RAW, 16'h0251, 1'b0, 7'h00);
    chk("tail offset 1", 8'h00, resp_status_out);
    run(OP_READ, FMT_RAW, 16'h0250, 1'b1, 7'h00);
    chk("tail block", 8'h00, resp_status_out);
    run(OP_READ, FMT_RAW, 16'h0041, 1'b1, 7'h00);
    chk("block offset", 8'h03, resp_status_out);
    run(OP_READ, FMT_RAW, 16'h0101, 1'b0, 7'h00);
    chk("small tail", 8'h03, resp_status_out);
    src_in = {64'h0, x_val, y_val};
    run(OP_WRITE, FMT_PUB, 16'h0040, 1'b0, 7'h00);
    chk("pub beats", 18, wq.size());
    for (int w = 0; w < 18; w++) begin
      chk("pub word", img[575-32*w -: 32], wq[w]);
    end
    img[575:572] = 4'ha;
    run(OP_READ, FMT_RAW, 16'h0040, 1'b1, 7'h00);
    chk("stored block", img[575:320], resp_data_out);
    for (int m = 0; m < 3; m++) begin
      sig_match_in = (m == 0);
      run(vops[m], FMT_RAW, 16'h0040, 1'b0, 7'h00);
      chk("validate status", m == 2 ? 8'h01 : 8'h00, resp_status_out);
      run(OP_READ, FMT_RAW, 16'h0040, 1'b0, 7'h00);
      chk("nibble", m == 0 ? 4'h5 : 4'ha, resp_data_out[255:252]);
    end
    run(OP_HASH_STORED, FMT_RAW, 16'h0040, 1'b0, 7'h00);
    chk("stored digest count", 72, sq.size());
    chk("stored digest last", 1, lasts);
    for (int i = 0; i < 72; i++) begin
      chk("stored digest byte", img[575-8*i -: 8], sq[i]);
    end
    run(OP_HASH_KEYGEN, FMT_RAW, 16'h0040, 1'b0, 7'h00);
    chk("keygen count", 89, sq.size());
    for (int i = 0; i < 89; i++) begin
      chk("keygen byte", kimg[711-8*i -: 8], sq[i]);
    end
    run(OP_WRITE, FMT_CERT, 16'h0048, 1'b0, 7'h00);
    chk("cert len 0", 8'h03, resp_status_out);
    run(OP_WRITE, FMT_CERT, 16'h0048, 1'b0, 7'h49);
    chk("cert len 73", 8'h03, resp_status_out);
    run(OP_WRITE, FMT_CERT, 16'h0048, 1'b0, 7'h48);
    chk("cert len 72", 18, wq.size());
    run(OP_WRITE, FMT_PUB, 16'h0028, 1'b0, 7'h00);
    chk("pub small slot", 8'h03, resp_status_out);
    src_in = {320'h0, x_val};
    run(OP_WRITE, FMT_PRIV, 16'h0048, 1'b0, 7'h00);
    chk("priv words", {32'h9, 32'h0, x_val[255:224]}, {wq.size(), wq[0], wq[1]});
    test_done();
  end
endmodule // data_zone_address_key_format_bench
`default_nettype wire
